// ---- shared/adl_map.svh ----
// register offsets, reset values and timing figures of the voice converter latch
// assumes a 32-bit apb slave, one aligned word per register
`ifndef ADL_MAP_SVH
`define ADL_MAP_SVH

`define ADL_OFF_WORD_HIGH    12'h000
`define ADL_OFF_WORD_LOW     12'h004
`define ADL_OFF_CONTROL      12'h008
`define ADL_OFF_SHADOW       12'h00C

`define ADL_RST_BYTE         8'h00
`define ADL_CTRL_ON_BIT      0
`define ADL_RST_ON           1'b0
`define ADL_RST_WORD         32'h0000_0000

// software settling wait after enabling the converter, in pclk cycles; plain default
`define ADL_SETTLE_CYCLES    8

`endif

// ---- shared/adl_pkg.sv ----
// types shared by the voice converter latch
// assumes adl_map.svh supplies the numeric constants
`default_nettype none

package adl_pkg;

  typedef struct packed {
    logic [15:0] word;
    logic        start;
    logic        on;
  } adl_conv_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
  } adl_acc_t;

endpackage

`default_nettype wire

// ---- tb/adl_latch_bench.sv ----
// bench for adl_latch: apb register tests of the voice converter latch
// assumes adl_map.svh offsets; every transfer waits on pready, the run timeout ends a hang
`timescale 1ns/10ps
`default_nettype none
`include "adl_map.svh"

module adl_latch_bench;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        [11:0] paddr;
  logic        [31:0] pwdata, prdata, rd;
  adl_pkg::adl_conv_t conv;
  int                 num_errors, n_checks, n_start, cyc, s;

  adl_latch dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv(conv));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // counts start pulses and cuts a hang short
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (conv.start === 1'b1) n_start <= n_start + 1;
    if (cyc == 1000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(nm, rd, exp);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc("high_rst", `ADL_OFF_WORD_HIGH, 8'h00);
    rc("low_rst", `ADL_OFF_WORD_LOW, 8'h00);
    rc("ctrl_rst", `ADL_OFF_CONTROL, 8'h00);
    chk("on_rst", conv.on, 1'b0);
    apb(1'b1, `ADL_OFF_CONTROL, 8'hFF);
    repeat (`ADL_SETTLE_CYCLES) @(posedge pclk);
    rc("ctrl_on", `ADL_OFF_CONTROL, 8'h01);
    chk("on", conv.on, 1'b1);
    apb(1'b1, `ADL_OFF_WORD_LOW, 8'h5A);
    @(negedge pclk);
    chk("word_hold", conv.word, 16'h0000);
    @(posedge pclk);
    rc("low_applied", `ADL_OFF_WORD_LOW, 8'h00);
    rc("shadow", `ADL_OFF_SHADOW, 8'h5A);
    s = n_start;
    apb(1'b1, `ADL_OFF_WORD_HIGH, 8'hC3);
    apb(1'b1, `ADL_OFF_WORD_HIGH, 8'h12);
    repeat (3) @(posedge pclk);
    chk("starts", n_start - s, 2);
    chk("word", conv.word, 16'h125A);
    rc("low_copy", `ADL_OFF_WORD_LOW, 8'h5A);
    rc("high", `ADL_OFF_WORD_HIGH, 8'h12);
    apb(1'b1, 12'h010, 8'h00);
    chk("err_wr", err, 1'b1);
    rc("unmapped", 12'h010, 8'h00);
    chk("err_rd", err, 1'b1);
    apb(1'b1, `ADL_OFF_SHADOW, 8'hEE);
    rc("shadow_kept", `ADL_OFF_SHADOW, 8'h5A);
    rc("ctrl_kept", `ADL_OFF_CONTROL, 8'h01);
    apb(1'b1, `ADL_OFF_CONTROL, 8'h00);
    @(negedge pclk);
    chk("off", conv.on, 1'b0);
    @(posedge pclk);
    // reset again in mid-run: the applied word and both data registers must return to zero
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("word_rst", conv.word, 16'h0000);
    presetn <= 1'b1;
    @(posedge pclk);
    rc("high_rst2", `ADL_OFF_WORD_HIGH, 8'h00);
    rc("low_rst2", `ADL_OFF_WORD_LOW, 8'h00);
    final_report();
  end
endmodule // adl_latch_bench
`default_nettype wire

// ---- verilog/adl_latch.sv ----
// apb register front end of the 16-bit voice converter latch
// assumes pclk at 10 MHz and an apb master that follows the usual two-phase protocol
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "adl_map.svh"

module adl_latch (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output adl_pkg::adl_conv_t conv
);

  // register state
  logic [7:0]        dac_word_high;
  logic [7:0]        dac_word_low;
  logic [7:0]        shadow_low;
  logic              converter_on;
  adl_pkg::adl_acc_t acc;

  // apb phases; a transfer takes effect only at the edge where pready is high
  wire               setup_phase = psel & ~penable;
  wire               access      = psel & penable & pready;
  assign acc = {access & pwrite, access & ~pwrite, paddr};

  // address decode
  wire               hit_high    = acc.addr == `ADL_OFF_WORD_HIGH;
  wire               hit_low     = acc.addr == `ADL_OFF_WORD_LOW;
  wire               hit_ctrl    = acc.addr == `ADL_OFF_CONTROL;
  wire               hit_shadow  = acc.addr == `ADL_OFF_SHADOW;
  wire               mapped      = hit_high | hit_low | hit_ctrl | hit_shadow;

  // write strobes; the shadow view at its own offset takes no writes
  wire               wr_high     = acc.wr & hit_high;
  wire               wr_low      = acc.wr & hit_low;
  wire               wr_ctrl     = acc.wr & hit_ctrl;

  // next register values; a high write copies the shadow into the low byte
  wire         [7:0] next_word_high  = wr_high ? pwdata[7:0] : dac_word_high;
  wire         [7:0] next_word_low   = wr_high ? shadow_low : dac_word_low;
  wire         [7:0] next_shadow_low = wr_low ? pwdata[7:0] : shadow_low;
  wire               next_on         = wr_ctrl ? pwdata[`ADL_CTRL_ON_BIT] : converter_on;

  // read mux, taken in the setup cycle so that the answer leaves a flip-flop
  wire         [7:0] rd_byte = hit_high   ? dac_word_high :
                               hit_low    ? dac_word_low :
                               hit_ctrl   ? {7'h00, converter_on} :
                               hit_shadow ? shadow_low : 8'h00;
  wire               rd_setup    = setup_phase & ~pwrite;
  wire               err_setup   = setup_phase & ~mapped;
  wire        [31:0] next_prdata = rd_setup ? {24'h00_0000, rd_byte} : `ADL_RST_WORD;

  // a low byte write lands in the shadow only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_low <= `ADL_RST_BYTE;
    end else begin
      shadow_low <= next_shadow_low;
    end
  end

  // the applied pair moves only on a high byte write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_word_high <= `ADL_RST_BYTE;
      dac_word_low  <= `ADL_RST_BYTE;
    end else begin
      dac_word_high <= next_word_high;
      dac_word_low  <= next_word_low;
    end
  end

  // converter enable, the only implemented control bit
  // settling after enable is left to software; nothing here counts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_on <= `ADL_RST_ON;
    end else begin
      converter_on <= next_on;
    end
  end

  // bus answer: ready, error and read data all come from the setup cycle
  // pready rises in every access cycle, so there are no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `ADL_RST_WORD;
    end else begin
      pready  <= setup_phase;
      pslverr <= err_setup;
      prdata  <= next_prdata;
    end
  end

  // word and start leave together, so the core never starts on a stale word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv.word  <= {`ADL_RST_BYTE, `ADL_RST_BYTE};
      conv.start <= 1'b0;
      conv.on    <= `ADL_RST_ON;
    end else begin
      conv.word  <= {next_word_high, next_word_low};
      conv.start <= wr_high;
      conv.on    <= next_on;
    end
  end

  // checks on the shadow and the applied word
  low_keeps_word_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_low |=> conv.word == $past(conv.word) && dac_word_low == $past(dac_word_low))
    else $error("low byte write changed the applied word");

  shadow_takes_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_low |=> shadow_low == $past(pwdata[7:0]))
    else $error("low byte write did not reach the shadow");

  shadow_holds_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_low |=> $stable(shadow_low))
    else $error("shadow changed without a low byte write");

  high_loads_word_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_high |=> dac_word_low == $past(shadow_low) && dac_word_high == $past(pwdata[7:0]))
    else $error("high byte write did not load the whole word");

  word_applied_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_high |=> conv.word == {$past(pwdata[7:0]), $past(shadow_low)})
    else $error("applied word does not match the high write and the shadow");

  pair_holds_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_high |=> $stable(dac_word_high) && $stable(dac_word_low))
    else $error("data registers changed without a high byte write");

  word_still_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_high |=> $stable(conv.word))
    else $error("applied word changed without a high byte write");

  // checks on the conversion start
  start_one_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_high |=> conv.start ##1 !conv.start)
    else $error("conversion start is not a single pulse after the high write");

  start_has_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    conv.start |-> $past(wr_high))
    else $error("conversion start without a high byte write");

  // checks on read back and control
  high_reads_back_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc.rd & hit_high |-> prdata == {24'h00_0000, dac_word_high})
    else $error("high data register read back wrong");

  low_reads_back_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc.rd & hit_low |-> prdata == {24'h00_0000, dac_word_low})
    else $error("low data register read back wrong");

  shadow_view_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc.rd & hit_shadow |-> prdata == {24'h00_0000, shadow_low})
    else $error("shadow view read back wrong");

  ctrl_upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc.rd & hit_ctrl |-> prdata == {31'h0, converter_on})
    else $error("control register read back wrong");

  enable_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> converter_on == $past(pwdata[`ADL_CTRL_ON_BIT]) && conv.on == converter_on)
    else $error("enable bit did not follow its write");

  enable_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_ctrl |=> $stable(converter_on))
    else $error("enable changed without a control write");

  // checks on the bus answer
  ready_after_setup_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase |=> pready)
    else $error("pready missing in the access cycle");

  ready_one_cycle_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready stood for more than one cycle");

  error_only_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready && !$past(mapped))
    else $error("pslverr on a mapped address or outside the access cycle");

  unmapped_reads_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc.rd & ~mapped |-> prdata == `ADL_RST_WORD)
    else $error("unmapped read returned non-zero data");

  shadow_no_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc.wr & hit_shadow |=> $stable(shadow_low) && $stable(conv.word))
    else $error("write to the shadow view changed state");

  // main scenarios
  cover_low_then_high: cover property (@(posedge pclk) disable iff (!presetn)
    wr_low ##[1:20] wr_high);
  cover_enable_on: cover property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl & pwdata[`ADL_CTRL_ON_BIT]);
  cover_start: cover property (@(posedge pclk) disable iff (!presetn) conv.start);
  cover_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pslverr & pready);
  cover_two_samples: cover property (@(posedge pclk) disable iff (!presetn)
    wr_high ##[2:4] wr_high);

endmodule // adl_latch

`default_nettype wire
